/* rtl/psicr_pkg.sv */
// shared constants and types for the phy status, ident and control register slice
package psicr_pkg;

  // register indices; the byte address is four times the index
  localparam int unsigned IDX_W        = 6;
  localparam logic [5:0]  IDX_IDENT    = 6'h03;  // identification word, low part
  localparam logic [5:0]  IDX_STATUS   = 6'h10;  // status snapshot
  localparam logic [5:0]  IDX_CTRL     = 6'h11;  // control setup
  localparam logic [5:0]  IDX_PINSTAT  = 6'h12;  // read clears the pin-asserted flag
  localparam logic [5:0]  IDX_EVT_STAT = 6'h20;  // sticky event status, read only
  localparam logic [5:0]  IDX_EVT_CLR  = 6'h21;  // write one to clear, write only
  localparam logic [5:0]  IDX_EVT_EN   = 6'h22;  // event enable

  // values after reset
  localparam logic [15:0] STATUS_RST = 16'h0004;
  localparam logic [15:0] CTRL_RST   = 16'h010B;
  // writable control bits: 15..7 and 3..0, bits 6..4 read as zero
  localparam logic [15:0] CTRL_WMASK = 16'hFF8F;

  // status word bit positions
  localparam int unsigned ST_RXERR  = 13;
  localparam int unsigned ST_CHAN   = 10;
  localparam int unsigned ST_LOCK   = 9;
  localparam int unsigned ST_PININT = 7;
  localparam int unsigned ST_JAB    = 5;
  localparam int unsigned ST_LOOP   = 3;
  localparam int unsigned ST_DUPLEX = 2;
  localparam int unsigned ST_LINK   = 0;

  // identification field layout
  localparam int unsigned ID_ORG_LSB   = 10;
  localparam int unsigned ID_MODEL_LSB = 4;

  // power save modes
  localparam logic [1:0] PSAVE_NORMAL = 2'h0;
  localparam logic [1:0] PSAVE_DOWN   = 2'h1;

  // event bits of the interrupt registers
  localparam int unsigned EVT_W         = 3;
  localparam int unsigned EVT_RXERR     = 0;
  localparam int unsigned EVT_CHAN_LOST = 1;
  localparam int unsigned EVT_LOCK_LOST = 2;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control word layout, msb first
  typedef struct packed {
    logic       refOff;           // stop driving ref_out_pin
    logic       pwrSaveEn;        // take power save mode from the register
    logic [1:0] pwrSaveMode;      // power save mode
    logic       sgmiiReset;       // self clearing
    logic       zeroAddrIsolatesMac;
    logic [1:0] txFifoDepth;      // rmii transmit fifo depth code
    logic       spare;            // read/write, no effect
    logic [2:0] zeros;            // read as zero
    logic       intPol;           // 1: pin idles high
    logic       forceIrq;         // force the interrupt pin
    logic       irqGate;          // enable interrupt generation on the pin
    logic       pinIsIrq;         // 1: shared pin is irq output
  } psicr_ctrl_t;

  // one register write as handed from the bus slave
  typedef struct packed {
    logic [5:0]  idx;
    logic [15:0] data;
    logic [1:0]  strb;
  } psicr_wr_t;

  // bus channel states
  typedef enum logic [1:0] {
    CH_IDLE = 2'b01,
    CH_RESP = 2'b10
  } psicr_ch_t;

endpackage : psicr_pkg

/* rtl/psicr_axil_slave.sv */
// axi4-lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
module psicr_axil_slave #(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  // write address and data
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // read channels
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // register side
  output logic                       wrStb,
  output psicr_pkg::psicr_wr_t       wrReq,
  input  wire logic                  wrOk,
  output logic                       rdStb,
  output logic [psicr_pkg::IDX_W-1:0] rdIdx,
  input  wire logic [15:0]           rdData,
  input  wire logic                  rdOk
);
  import psicr_pkg::*;

  // the index must cover the highest register
  if (ADDR_W < IDX_W + 2) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  psicr_ch_t         wrSt_q, wrSt_d;      // write channel state
  psicr_ch_t         rdSt_q, rdSt_d;      // read channel state
  logic              haveAw_q, haveAw_d;  // address captured
  logic              haveW_q, haveW_d;    // data captured
  psicr_wr_t         req_q, req_d;        // captured write
  logic [1:0]        bresp_d, rresp_d;
  logic [31:0]       rdata_d;

  assign s_axi_awready = (wrSt_q == CH_IDLE) && !haveAw_q;
  assign s_axi_wready  = (wrSt_q == CH_IDLE) && !haveW_q;
  assign s_axi_arready = (rdSt_q == CH_IDLE);
  assign s_axi_bvalid  = (wrSt_q == CH_RESP);
  assign s_axi_rvalid  = (rdSt_q == CH_RESP);
  assign wrReq         = req_q;
  // write fires once both halves are held, in either order
  assign wrStb         = (wrSt_q == CH_IDLE) && haveAw_q && haveW_q;
  // read side effects tie to the one address handshake
  assign rdStb         = s_axi_arvalid && s_axi_arready;
  assign rdIdx         = s_axi_araddr[IDX_W+1:2];

  // next state of both channels
  always_comb begin
    wrSt_d   = wrSt_q;
    rdSt_d   = rdSt_q;
    haveAw_d = haveAw_q;
    haveW_d  = haveW_q;
    req_d    = req_q;
    bresp_d  = s_axi_bresp;
    rresp_d  = s_axi_rresp;
    rdata_d  = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      haveAw_d  = 1'b1;
      req_d.idx = s_axi_awaddr[IDX_W+1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      haveW_d    = 1'b1;
      req_d.data = s_axi_wdata[15:0];
      req_d.strb = s_axi_wstrb[1:0];
    end
    case (wrSt_q)
      CH_IDLE: begin
        if (wrStb) begin
          wrSt_d  = CH_RESP;
          bresp_d = wrOk ? RESP_OKAY : RESP_SLVERR;
        end
      end
      CH_RESP: begin
        if (s_axi_bready) begin
          wrSt_d   = CH_IDLE;
          haveAw_d = 1'b0;
          haveW_d  = 1'b0;
        end
      end
      default: wrSt_d = CH_IDLE;
    endcase
    case (rdSt_q)
      CH_IDLE: begin
        if (rdStb) begin
          rdSt_d  = CH_RESP;
          rdata_d = rdOk ? {16'h0000, rdData} : 32'h00000000;
          rresp_d = rdOk ? RESP_OKAY : RESP_SLVERR;
        end
      end
      CH_RESP: begin
        if (s_axi_rready) begin
          rdSt_d = CH_IDLE;
        end
      end
      default: rdSt_d = CH_IDLE;
    endcase
  end

  // channel registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrSt_q      <= CH_IDLE;
      rdSt_q      <= CH_IDLE;
      haveAw_q    <= 1'b0;
      haveW_q     <= 1'b0;
      req_q       <= '0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      wrSt_q      <= wrSt_d;
      rdSt_q      <= rdSt_d;
      haveAw_q    <= haveAw_d;
      haveW_q     <= haveW_d;
      req_q       <= req_d;
      s_axi_bresp <= bresp_d;
      s_axi_rresp <= rresp_d;
      s_axi_rdata <= rdata_d;
    end
  end

endmodule : psicr_axil_slave

/* rtl/psicr_irq_pin.sv */
// shared interrupt / power-down pin: polarity, direction and power-down request
`timescale 1ns/1ps
module psicr_irq_pin (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  // configuration and request
  input  wire psicr_pkg::psicr_ctrl_t ctrl,
  input  wire logic                 irqSrc,
  // pin
  input  wire logic                 pinIn,
  output logic                      pinOut_q,
  output logic                      pinOeN_q,
  // results
  output logic                      pinAsserted,
  output logic                      powerDown_q
);
  import psicr_pkg::*;

  logic pinOut_d;      // pin level next
  logic pinOeN_d;      // low while driving
  logic powerDown_d;   // power-down request next
  logic modeDown;      // power save asks for power down

  // forcing bypasses the gate so a board test can toggle the pin
  assign pinAsserted = ctrl.pinIsIrq && (ctrl.forceIrq || (ctrl.irqGate && irqSrc));
  // register mode only counts when enabled
  assign modeDown = ctrl.pwrSaveEn && (ctrl.pwrSaveMode == PSAVE_DOWN);

  // pin next values
  always_comb begin
    pinOut_d    = pinAsserted ^ ctrl.intPol;
    pinOeN_d    = !ctrl.pinIsIrq;
    // as an input the pin requests power down while high
    powerDown_d = modeDown || (!ctrl.pinIsIrq && pinIn);
  end

  // pin registers; reset idles the pin high for the default polarity
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinOut_q    <= 1'b1;
      pinOeN_q    <= 1'b0;
      powerDown_q <= 1'b0;
    end else begin
      pinOut_q    <= pinOut_d;
      pinOeN_q    <= pinOeN_d;
      powerDown_q <= powerDown_d;
    end
  end

endmodule : psicr_irq_pin

/* rtl/psicr_top.sv */
// phy status, identification and control registers behind an axi4-lite port
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module psicr_top #(
  parameter int unsigned ADDR_W    = 8,
  parameter logic [5:0]  ORG_LOW   = 6'h15,  // arbitrary value
  parameter logic [5:0]  MODEL     = 6'h0A,  // arbitrary value
  parameter logic [3:0]  REVISION  = 4'h2    // arbitrary value
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // axi4-lite register port
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // datapath state
  input  wire logic              rxErrSeen,
  input  wire logic              chanGood,
  input  wire logic              descLocked,
  input  wire logic              linkUp,
  input  wire logic              jabberSeen,
  input  wire logic              miiLoopback,
  input  wire logic              fullDuplex,
  input  wire logic              irqSrc,
  // shared interrupt / power-down pin
  input  wire logic              irqPinIn,
  output logic                   irqPinOut,
  output logic                   irqPinOeN,
  // configuration outputs
  output logic                   refOutPinEn,
  output logic                   powerDown,
  output logic [1:0]             pwrSaveModeOut,
  output logic                   sgmiiResetPulse,
  output logic                   zeroAddrIsolatesMac,
  output logic [1:0]             txFifoDepth,
  // block interrupt
  output logic                   irqOut
);
  import psicr_pkg::*;

  // bus strobes
  logic                wrStb;        // one register write
  psicr_wr_t           wrReq;        // its index, data, strobes
  logic                wrOk;         // write index is writable
  logic                rdStb;        // one register read
  logic [IDX_W-1:0]    rdIdx;        // read index
  logic [15:0]         rdData;       // read value, this cycle
  logic                rdOk;         // read index is readable

  // status state
  logic                rxErr_q, rxErr_d;      // receive error latch
  logic                chan_q, chan_d;        // channel good, latch low
  logic                lock_q, lock_d;        // descrambler lock, latch low
  logic                pinInt_q, pinInt_d;    // interrupt pin had been set
  logic                link_q, jab_q;         // mirrors
  logic                loop_q, dup_q;
  logic                chanPrev_q, lockPrev_q; // edge history
  logic [15:0]         statusWord;            // assembled status

  // control and interrupt state
  psicr_ctrl_t         ctrl_q, ctrl_d;
  logic [EVT_W-1:0]    evtStat_q, evtStat_d;  // sticky events
  logic [EVT_W-1:0]    evtEn_q, evtEn_d;      // event enables
  logic [EVT_W-1:0]    evtHit;                // events this cycle
  logic [EVT_W-1:0]    evtClr;                // clear strobes this cycle
  logic                pinAsserted;           // pin being asserted now

  // decoded accesses
  logic                rdStatus, rdPinStat;
  logic                wrCtrl, wrEn, wrClr;

  psicr_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_bus (
    .core_clk      (core_clk),
    .arst_n        (arst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrStb         (wrStb),
    .wrReq         (wrReq),
    .wrOk          (wrOk),
    .rdStb         (rdStb),
    .rdIdx         (rdIdx),
    .rdData        (rdData),
    .rdOk          (rdOk)
  );

  psicr_irq_pin u_pin (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .ctrl        (ctrl_q),
    .irqSrc      (irqSrc),
    .pinIn       (irqPinIn),
    .pinOut_q    (irqPinOut),
    .pinOeN_q    (irqPinOeN),
    .pinAsserted (pinAsserted),
    .powerDown_q (powerDown)
  );

  // access decode; unmapped or wrong-way accesses fail
  assign rdStatus  = rdStb && (rdIdx == IDX_STATUS);
  assign rdPinStat = rdStb && (rdIdx == IDX_PINSTAT);
  assign wrCtrl    = wrStb && (wrReq.idx == IDX_CTRL);
  assign wrEn      = wrStb && (wrReq.idx == IDX_EVT_EN);
  assign wrClr     = wrStb && (wrReq.idx == IDX_EVT_CLR);
  assign wrOk      = (wrReq.idx == IDX_CTRL) || (wrReq.idx == IDX_EVT_EN) ||
                     (wrReq.idx == IDX_EVT_CLR);
  assign rdOk      = (rdIdx == IDX_IDENT) || (rdIdx == IDX_STATUS) ||
                     (rdIdx == IDX_CTRL) || (rdIdx == IDX_PINSTAT) ||
                     (rdIdx == IDX_EVT_STAT) || (rdIdx == IDX_EVT_EN);

  // status word before this read's side effects
  always_comb begin
    statusWord            = 16'h0000;
    statusWord[ST_RXERR]  = rxErr_q;
    statusWord[ST_CHAN]   = chan_q;
    statusWord[ST_LOCK]   = lock_q;
    statusWord[ST_PININT] = pinInt_q;
    statusWord[ST_JAB]    = jab_q;
    statusWord[ST_LOOP]   = loop_q;
    statusWord[ST_DUPLEX] = dup_q;
    statusWord[ST_LINK]   = link_q;
  end

  // read mux, taken with the side effects
  always_comb begin
    rdData = 16'h0000;
    case (rdIdx)
      IDX_IDENT:    rdData = {ORG_LOW, MODEL, REVISION};
      IDX_STATUS:   rdData = statusWord;
      IDX_CTRL:     rdData = ctrl_q & CTRL_WMASK;
      IDX_EVT_STAT: rdData = {{(16-EVT_W){1'b0}}, evtStat_q};
      IDX_EVT_EN:   rdData = {{(16-EVT_W){1'b0}}, evtEn_q};
      default:      rdData = 16'h0000;                    // pin status word reads zero
    endcase
  end

  // status latches; a new event beats the clearing read
  always_comb begin
    // receive error: set wins over the read that clears it
    rxErr_d  = rxErrSeen || (rxErr_q && !rdStatus);
    // latch low: a drop holds 0, a read re-arms to the live level
    chan_d   = chanGood && (chan_q || rdStatus);
    lock_d   = descLocked && (lock_q || rdStatus);
    // pin asserted flag only clears on a read of the pin status word
    pinInt_d = pinAsserted || (pinInt_q && !rdPinStat);
  end

  // status registers; mirrors follow their sources one clock later
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxErr_q    <= STATUS_RST[ST_RXERR];
      chan_q     <= STATUS_RST[ST_CHAN];
      lock_q     <= STATUS_RST[ST_LOCK];
      pinInt_q   <= STATUS_RST[ST_PININT];
      link_q     <= STATUS_RST[ST_LINK];
      jab_q      <= STATUS_RST[ST_JAB];
      loop_q     <= STATUS_RST[ST_LOOP];
      dup_q      <= STATUS_RST[ST_DUPLEX];
      chanPrev_q <= 1'b0;
      lockPrev_q <= 1'b0;
    end else begin
      rxErr_q    <= rxErr_d;
      chan_q     <= chan_d;
      lock_q     <= lock_d;
      pinInt_q   <= pinInt_d;
      link_q     <= linkUp;
      jab_q      <= jabberSeen;
      loop_q     <= miiLoopback;
      dup_q      <= fullDuplex;
      chanPrev_q <= chanGood;
      lockPrev_q <= descLocked;
    end
  end

  // events that feed the sticky interrupt status
  assign evtHit[EVT_RXERR]     = rxErrSeen;
  assign evtHit[EVT_CHAN_LOST] = chanPrev_q && !chanGood;
  assign evtHit[EVT_LOCK_LOST] = lockPrev_q && !descLocked;
  assign evtClr                = wrClr && wrReq.strb[0] ? wrReq.data[EVT_W-1:0] : '0;

  // control and interrupt next values with byte lanes honoured
  always_comb begin
    ctrl_d            = ctrl_q;
    // soft reset bit lives for one clock only
    ctrl_d.sgmiiReset = 1'b0;
    if (wrCtrl) begin
      if (wrReq.strb[0]) begin
        ctrl_d[7:0] = wrReq.data[7:0] & CTRL_WMASK[7:0];
      end
      if (wrReq.strb[1]) begin
        ctrl_d[15:8] = wrReq.data[15:8];
      end
    end
    evtEn_d = evtEn_q;
    if (wrEn && wrReq.strb[0]) begin
      evtEn_d = wrReq.data[EVT_W-1:0];
    end
    // a clear never hides an event of the same cycle
    evtStat_d = (evtStat_q & ~evtClr) | evtHit;
  end

  // control, interrupt and output registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q              <= CTRL_RST;
      evtEn_q             <= '0;
      evtStat_q           <= '0;
      irqOut              <= 1'b0;
      refOutPinEn         <= !CTRL_RST[15];
      pwrSaveModeOut      <= PSAVE_NORMAL;
      sgmiiResetPulse     <= 1'b0;
      zeroAddrIsolatesMac <= CTRL_RST[10];
      txFifoDepth         <= CTRL_RST[9:8];
    end else begin
      ctrl_q              <= ctrl_d;
      evtEn_q             <= evtEn_d;
      evtStat_q           <= evtStat_d;
      irqOut              <= |(evtStat_d & evtEn_d);
      refOutPinEn         <= !ctrl_d.refOff;
      pwrSaveModeOut      <= ctrl_d.pwrSaveEn ? ctrl_d.pwrSaveMode : PSAVE_NORMAL;
      sgmiiResetPulse     <= ctrl_d.sgmiiReset;
      zeroAddrIsolatesMac <= ctrl_d.zeroAddrIsolatesMac;
      txFifoDepth         <= ctrl_d.txFifoDepth;
    end
  end

endmodule : psicr_top

/* tb/psicr_monitor.sv */
// bus handshake and pin checks for the status, ident and control slice
`timescale 1ns/1ps
module psicr_monitor (
  // clock, reset and bus
  input wire logic        core_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  // pin and control outputs
  input wire logic        irqPinIn, irqPinOeN, powerDown, sgmiiResetPulse,
  input wire logic [1:0]  pwrSaveModeOut
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // a taken read is answered on the next cycle
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read dropped");
  rd_upper_a: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:16] == 16'h0000)
    else $error("read busy or upper half set");
  // both write halves together give a response two edges later
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  // pin as input: a high level requests power down
  pin_input_a: assert property (irqPinIn ##1 irqPinOeN |-> powerDown)
    else $error("pin input ignored");
  psave_down_a: assert property (pwrSaveModeOut == 2'h1 |=> powerDown)
    else $error("power save ignored");
  sgmii_pulse_a: assert property (sgmiiResetPulse |=> !sgmiiResetPulse)
    else $error("reset pulse too long");
  rd_c: cover property (s_axi_rvalid && s_axi_rready);
  wr_c: cover property (s_axi_bvalid && s_axi_bready);
  pd_c: cover property (powerDown && irqPinOeN);
endmodule : psicr_monitor
bind psicr_top psicr_monitor mon_u (.*);

/* tb/psicr_host_model.sv */
// management host model: axi4-lite master, one transfer at a time
`timescale 1ns/1ps
module psicr_host_model (
  // clock
  input wire logic        core_clk,
  // master side of the bus
  output logic [7:0]      s_axi_awaddr, s_axi_araddr,
  output logic [31:0]     s_axi_wdata,
  output logic [3:0]      s_axi_wstrb,
  output logic            s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
  // slave answers
  input wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  // idle bus, low two byte lanes always on
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end
  // write: each half released once taken
  task automatic wr(input logic [5:0] idx, input logic [15:0] d, output logic [1:0] resp);
    @(posedge core_clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (1'b1) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  // read: waits for rvalid, watchdog cuts a hang
  task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
    @(posedge core_clk);
    s_axi_araddr <= {idx, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (1'b1) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd
endmodule : psicr_host_model

/* tb/psicr_tb_top.sv */
// self-checking bench for the phy status, ident and control registers
`timescale 1ns/1ps
module psicr_tb_top;
  import psicr_pkg::*;
  localparam logic [5:0] ORG = 6'h15; // arbitrary value
  localparam logic [5:0] MDL = 6'h0A; // arbitrary value
  localparam logic [3:0] REV = 4'h2;  // arbitrary value
  logic core_clk = 1'b0, arst_n = 1'b0;
  logic rxErrSeen = 1'b0, chanGood = 1'b0, descLocked = 1'b0, linkUp = 1'b0, jabberSeen = 1'b0;
  logic miiLoopback = 1'b0, fullDuplex = 1'b1, irqSrc = 1'b0, irqPinIn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, pwrSaveModeOut, txFifoDepth;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irqPinOut, irqPinOeN;
  logic refOutPinEn, powerDown, sgmiiResetPulse, zeroAddrIsolatesMac, irqOut;
  int mismatches = 0, comparisons = 0;
  always #25 core_clk = ~core_clk;
  psicr_host_model host_u (.*);
  psicr_top #(.ORG_LOW(ORG), .MODEL(MDL), .REVISION(REV)) dut_u (.*);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // register read and write with response check
  task automatic rd(input logic [5:0] idx, input logic [15:0] exp, input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    host_u.rd(idx, d, r);
    cmp(d, {16'h0000, exp});
    cmp(32'(r), 32'(er));
  endtask : rd
  task automatic wrc(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] er = RESP_OKAY);
    logic [1:0] r;
    host_u.wr(idx, d, r);
    cmp(32'(r), 32'(er));
  endtask : wrc
  // pin outputs are registered one clock behind the control word
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic pin(input logic [2:0] e);
    settle();
    cmp({irqPinOut, irqPinOeN, powerDown}, {29'h0, e});
  endtask : pin
  task automatic irq(input logic e);
    settle();
    cmp({31'h0, irqOut}, {31'h0, e});
  endtask : irq
  task automatic t_reset;
    rd(IDX_STATUS, STATUS_RST);
    rd(IDX_CTRL, CTRL_RST);
    rd(IDX_IDENT, {ORG, MDL, REV});
    $display("reset done");
  endtask : t_reset
  task automatic t_pin;
    pin(3'h4);
    @(posedge core_clk) irqSrc <= 1'b1;
    pin(3'h0);
    @(posedge core_clk) irqSrc <= 1'b0;
    rd(IDX_STATUS, STATUS_RST | 16'h0080);
    rd(IDX_PINSTAT, 16'h0000);
    rd(IDX_STATUS, STATUS_RST);
    wrc(IDX_CTRL, 16'h0103);
    @(posedge core_clk) irqSrc <= 1'b1;
    pin(3'h4);
    wrc(IDX_CTRL, 16'h0101);
    pin(3'h0);
    @(posedge core_clk) {irqSrc, irqPinIn} <= 2'b01;
    wrc(IDX_CTRL, 16'h0100);
    pin(3'h3);
    @(posedge core_clk) irqPinIn <= 1'b0;
    rd(IDX_PINSTAT, 16'h0000);
    $display("pin done");
  endtask : t_pin
  task automatic t_status;
    @(posedge core_clk) {linkUp, jabberSeen, miiLoopback, chanGood, descLocked, rxErrSeen} <= '1;
    @(posedge core_clk) rxErrSeen <= 1'b0;
    settle();
    rd(IDX_STATUS, 16'h202D);
    rd(IDX_STATUS, 16'h062D);
    @(posedge core_clk) {chanGood, descLocked} <= 2'b00;
    @(posedge core_clk) {chanGood, descLocked} <= 2'b11;
    settle();
    rd(IDX_STATUS, 16'h002D);
    rd(IDX_STATUS, 16'h062D);
    $display("status done");
  endtask : t_status
  task automatic t_psave;
    wrc(IDX_CTRL, 16'hD100);
    settle();
    cmp({refOutPinEn, pwrSaveModeOut, powerDown}, {28'h0, 1'b0, PSAVE_DOWN, 1'b1});
    wrc(IDX_CTRL, 16'h9100);
    settle();
    cmp({refOutPinEn, pwrSaveModeOut, powerDown}, {28'h0, 1'b0, PSAVE_NORMAL, 1'b0});
    rd(IDX_CTRL, 16'h9100);
    wrc(IDX_CTRL, 16'hFFFF);
    cmp({zeroAddrIsolatesMac, txFifoDepth}, 32'h7);
    rd(IDX_CTRL, CTRL_WMASK & 16'hF7FF);
    wrc(IDX_CTRL, CTRL_RST);
    $display("psave done");
  endtask : t_psave
  task automatic t_irq;
    wrc(IDX_EVT_EN, 16'h0007);
    wrc(IDX_EVT_CLR, 16'h0007);
    irq(1'b0);
    @(posedge core_clk) chanGood <= 1'b0;
    irq(1'b1);
    rd(IDX_EVT_STAT, 16'h0002);
    wrc(IDX_EVT_EN, 16'h0000);
    irq(1'b0);
    @(posedge core_clk) chanGood <= 1'b1;
    wrc(IDX_EVT_EN, 16'h0007);
    wrc(IDX_EVT_CLR, 16'h0002);
    irq(1'b0);
    rd(IDX_EVT_CLR, 16'h0000, RESP_SLVERR);
    rd(6'h3F, 16'h0000, RESP_SLVERR);
    wrc(IDX_STATUS, 16'hFFFF, RESP_SLVERR);
    $display("irq done");
  endtask : t_irq
  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // watchdog well past the tests' length
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_pin();
    t_status();
    t_psave();
    t_irq();
    tally_and_finish();
  end
endmodule : psicr_tb_top
